/* File: verilog/rtu_slave_end.sv */
// Slave end: receives request frames, runs echo and multi-word write,
// and answers with a reply or an exception frame.
// Assumes the parameter store sits outside and answers chk_* at once.
`include "rtu_link_cfg.svh"

// Overview of operation
// - Echo sub-function zero request byte for byte.
// - Echo frame: address, command, sub, data, check.
// - Write carries at most sixteen words.
// - Master write frame layout, count, bytes, data.
// - Write reply: address, command, start, count, check.
// - Frames delimited by 3.5 character idle gaps.
// - Stored value is integer over ten power n.
// - Master scales fractions before sending.
// - Unserviceable request gets exception reply.
// - Code 01 for unknown command or fault.
// - Code 02 for address range overflow.
// - Code 03 for bad structural field.
// - Code 04 for conflicting parameter setting.
// - Code 05 for wrong password.
// - Code 06 for bad length or check.
// - Code 07 for read-only parameter, unchanged.
// - Code 08 for run-protected write while running.
// - Code 09 while locked without password.
// - Check low byte first, fields high first.
// - Accept own address only; reply with it.
module rtu_slave_end #(
  parameter logic [7:0] slave_addr = 8'h01,
  parameter int unsigned char_cycles = `CFG_CHAR_CYCLES,
  parameter int unsigned gap_cycles = `CFG_GAP_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  rtu_link_if.device link,
  output rtu_link_pkg::word_t chk_addr,
  input wire logic chk_read_only,
  input wire logic chk_run_locked,
  input wire logic chk_conflict,
  input wire logic [1:0] chk_decimals,
  input wire logic drive_fault,
  input wire logic drive_running,
  input wire logic sys_locked,
  input wire rtu_link_pkg::word_t user_password_setting,
  output logic wr_stb,
  output rtu_link_pkg::word_t wr_addr,
  output rtu_link_pkg::word_t wr_raw,
  output rtu_link_pkg::word_t wr_whole,
  output rtu_link_pkg::word_t wr_frac,
  output logic unlock_stb
);
  import rtu_link_pkg::*;

  // ==========================================================
  // Receive buffer and frame fields
  byte_t buf_r [`CFG_BUF_BYTES];
  logic [5:0] len_r;
  logic ovf_r;
  word_t crc_r;
  logic [31:0] idle_r;
  dev_state_t st_r;
  logic [4:0] idx_r;
  word_t start_w, qty_w, word_w;
  logic frame_end, tx_last;

  assign start_w = {buf_r[2], buf_r[3]};
  assign qty_w = {buf_r[4], buf_r[5]};
  // Word idx_r of a write payload, high byte first.
  assign word_w = {buf_r[7 + 2 * idx_r], buf_r[8 + 2 * idx_r]};
  assign chk_addr = start_w + {11'h000, idx_r};
  assign frame_end = (st_r == DS_RX) && (len_r != 6'd0) &&
                     (idle_r == gap_cycles - 1);

  // Idle counter restarts on every received byte.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_r <= '0;
    end else if (link.m2s_stb || st_r != DS_RX) begin
      idle_r <= '0;
    end else if (idle_r != gap_cycles - 1) begin
      idle_r <= idle_r + 32'd1;
    end
  end

  // Bytes are stored and summed; running the sum over the trailing
  // check bytes leaves zero for an intact frame, so no compare word.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      len_r <= '0;
      ovf_r <= 1'b0;
      crc_r <= `CFG_CRC_INIT;
    end else if ((st_r == DS_TX && tx_last) ||
                 (st_r == DS_EVAL && buf_r[0] != slave_addr)) begin
      len_r <= '0;
      ovf_r <= 1'b0;
      crc_r <= `CFG_CRC_INIT;
    end else if (st_r == DS_RX && link.m2s_stb) begin
      crc_r <= crc_step(crc_r, link.m2s_data);
      if (len_r == 6'(`CFG_BUF_BYTES)) begin
        ovf_r <= 1'b1;
      end else begin
        buf_r[len_r] <= link.m2s_data;
        len_r <= len_r + 6'd1;
      end
    end
  end

  // ==========================================================
  // Request decode and checks
  logic [5:0] body_r;
  logic add_crc_r;
  logic err_r;
  byte_t code_r;
  logic [31:0] cnt_r;
  logic [5:0] tx_idx_r;
  word_t tx_crc_r;

  // Exception for the word under scan, zero when it passes.
  byte_t scan_code;
  always_comb begin
    scan_code = 8'h00;
    if (sys_locked && chk_addr != `CFG_PWD_ADDR) begin
      scan_code = `CFG_EXC_LOCKED;
    end else if (chk_addr == `CFG_PWD_ADDR &&
                 word_w != user_password_setting) begin
      scan_code = `CFG_EXC_PWD;
    end else if (chk_read_only) begin
      scan_code = `CFG_EXC_RDONLY;
    end else if (drive_running && chk_run_locked) begin
      scan_code = `CFG_EXC_RUNNING;
    end else if (chk_conflict) begin
      scan_code = `CFG_EXC_OPER;
    end
  end

  // Main sequence; a failed scan leaves every parameter untouched
  // because writes only start once all words have passed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= DS_RX;
      idx_r <= '0;
      body_r <= '0;
      add_crc_r <= 1'b0;
      err_r <= 1'b0;
      code_r <= 8'h00;
    end else begin
      unique case (st_r)
        DS_RX: st_r <= frame_end ? DS_EVAL : DS_RX;
        DS_EVAL: begin
          st_r <= DS_TX;
          err_r <= 1'b1;
          body_r <= 6'd3;
          add_crc_r <= 1'b1;
          idx_r <= '0;
          if (buf_r[0] != slave_addr) begin
            st_r <= DS_RX;
          end else if (ovf_r || len_r < 6'd4 || crc_r != 16'h0000) begin
            code_r <= `CFG_EXC_FRAME;
          end else if (drive_fault || (buf_r[1] != `CFG_CMD_DIAG &&
                       buf_r[1] != `CFG_CMD_WRITE)) begin
            code_r <= `CFG_EXC_CMD;
          end else if (buf_r[1] == `CFG_CMD_DIAG) begin
            if (len_r != 6'd8) begin
              code_r <= `CFG_EXC_FRAME;
            end else if (start_w != `CFG_SUB_ECHO) begin
              code_r <= `CFG_EXC_VALUE;
            end else begin
              err_r <= 1'b0;
              body_r <= len_r;
              add_crc_r <= 1'b0;
            end
          end else if (qty_w == 16'h0000 || qty_w > `CFG_MAX_WORDS) begin
            code_r <= `CFG_EXC_VALUE;
          end else if ({8'h00, buf_r[6]} != {qty_w[14:0], 1'b0}) begin
            code_r <= `CFG_EXC_VALUE;
          end else if ({10'h000, len_r} != qty_w * 2 + 16'd9) begin
            code_r <= `CFG_EXC_FRAME;
          end else if ({1'b0, start_w} + {1'b0, qty_w} >
                       `CFG_ADDR_SPAN) begin
            code_r <= `CFG_EXC_ADDR;
          end else begin
            st_r <= DS_SCAN;
          end
        end
        DS_SCAN: begin
          if (scan_code != 8'h00) begin
            st_r <= DS_TX;
            code_r <= scan_code;
          end else if ({11'h000, idx_r} == qty_w - 16'd1) begin
            st_r <= DS_APPLY;
            idx_r <= '0;
          end else begin
            idx_r <= idx_r + 5'd1;
          end
        end
        DS_APPLY: begin
          if ({11'h000, idx_r} == qty_w - 16'd1) begin
            // reply of six bytes plus check
            st_r <= DS_TX;
            err_r <= 1'b0;
            body_r <= 6'd6;
          end else begin
            idx_r <= idx_r + 5'd1;
          end
        end
        DS_TX: st_r <= tx_last ? DS_RX : DS_TX;
      endcase
    end
  end

  // ==========================================================
  // Parameter write port
  // split by fieldbus scale
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      wr_stb <= 1'b0;
      unlock_stb <= 1'b0;
      wr_addr <= '0;
      wr_raw <= '0;
      wr_whole <= '0;
      wr_frac <= '0;
    end else begin
      wr_stb <= (st_r == DS_APPLY);
      unlock_stb <= (st_r == DS_APPLY) && (chk_addr == `CFG_PWD_ADDR);
      if (st_r == DS_APPLY) begin
        wr_addr <= chk_addr;
        wr_raw <= word_w;
        wr_whole <= word_w / pow10(chk_decimals);
        wr_frac <= word_w % pow10(chk_decimals);
      end
    end
  end

  // ==========================================================
  // Transmitter, one byte per character time
  byte_t body_byte;
  logic [5:0] tx_total;
  logic tx_tick;

  assign tx_total = body_r + (add_crc_r ? 6'd2 : 6'd0);
  assign tx_tick = (st_r == DS_TX) && (cnt_r == 0);
  assign tx_last = tx_tick && (tx_idx_r == tx_total - 6'd1);

  always_comb begin
    body_byte = buf_r[tx_idx_r];
    if (err_r) begin
      unique case (tx_idx_r)
        6'd0: body_byte = slave_addr;
        6'd1: body_byte = buf_r[1] | `CFG_ERR_FLAG;
        default: body_byte = code_r;
      endcase
    end
  end

  // Pacing divider; the first byte goes out at once since the
  // receive gap has already elapsed.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (st_r != DS_TX || cnt_r == char_cycles - 1) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 32'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_idx_r <= '0;
      tx_crc_r <= `CFG_CRC_INIT;
      link.s2m_stb <= 1'b0;
      link.s2m_data <= 8'h00;
    end else begin
      link.s2m_stb <= tx_tick;
      if (st_r != DS_TX) begin
        tx_idx_r <= '0;
        tx_crc_r <= `CFG_CRC_INIT;
      end else if (tx_tick) begin
        tx_idx_r <= tx_idx_r + 6'd1;
        if (tx_idx_r < body_r) begin
          link.s2m_data <= body_byte;
          tx_crc_r <= crc_step(tx_crc_r, body_byte);
        end else if (tx_idx_r == body_r) begin
          link.s2m_data <= tx_crc_r[7:0];
        end else begin
          link.s2m_data <= tx_crc_r[15:8];
        end
      end
    end
  end
endmodule : rtu_slave_end

/* File: pkg/rtu_link_cfg.svh */
// Constants shared by both ends of the serial command link.
// Assumes one 250 MHz clock; line pacing is counted in clock cycles.
`ifndef RTU_LINK_CFG_SVH
`define RTU_LINK_CFG_SVH
// ==========================================================
// Timing
`define CFG_CLK_NS 4
`define CFG_CHAR_NS 572917
`define CFG_CHAR_CYCLES (`CFG_CHAR_NS / `CFG_CLK_NS)
`define CFG_GAP_NS (`CFG_CHAR_NS * 7 / 2)
`define CFG_GAP_CYCLES ((`CFG_GAP_NS + `CFG_CLK_NS - 1) / `CFG_CLK_NS)
`define CFG_RSP_TIMEOUT_CYCLES (`CFG_GAP_CYCLES * 4)
// ==========================================================
// Frame layout and codes
`define CFG_BUF_BYTES 48
`define CFG_MAX_WORDS 16
`define CFG_CMD_DIAG 8'h08
`define CFG_CMD_WRITE 8'h10
`define CFG_SUB_ECHO 16'h0000
`define CFG_ERR_FLAG 8'h80
`define CFG_CRC_INIT 16'hFFFF
`define CFG_CRC_POLY 16'hA001
`define CFG_PWD_ADDR 16'h0F00
`define CFG_ADDR_SPAN 17'h10000
`define CFG_EXC_CMD 8'h01
`define CFG_EXC_ADDR 8'h02
`define CFG_EXC_VALUE 8'h03
`define CFG_EXC_OPER 8'h04
`define CFG_EXC_PWD 8'h05
`define CFG_EXC_FRAME 8'h06
`define CFG_EXC_RDONLY 8'h07
`define CFG_EXC_RUNNING 8'h08
`define CFG_EXC_LOCKED 8'h09
`endif

/* File: pkg/rtu_link_pkg.sv */
// Types and helper functions shared by both ends of the link.
// Assumes rtu_link_cfg.svh is on the include path.
`include "rtu_link_cfg.svh"
package rtu_link_pkg;
  // ==========================================================
  // Types
  typedef logic [7:0] byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0] {
    DS_RX, DS_EVAL, DS_SCAN, DS_APPLY, DS_TX
  } dev_state_t;
  typedef enum logic [1:0] {
    HS_IDLE, HS_TX, HS_RSP
  } host_state_t;

  // One byte step of the reflected 16-bit check sum.
  function automatic word_t crc_step(word_t crc, byte_t b);
    word_t c;
    c = crc ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      c = c[0] ? ((c >> 1) ^ `CFG_CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction : crc_step

  // Fieldbus scale: ten to the power of the decimal places.
  function automatic word_t pow10(logic [1:0] n);
    unique case (n)
      2'd0: return 16'h0001;
      2'd1: return 16'h000A;
      2'd2: return 16'h0064;
      2'd3: return 16'h03E8;
    endcase
  endfunction : pow10
endpackage : rtu_link_pkg

/* File: pkg/rtu_link_if.sv */
// Byte-level link between the master end and the slave end.
// Assumes each byte is one clock-wide strobe, paced one per character.
interface rtu_link_if (
  input wire logic clk,
  input wire logic rstn
);
  logic m2s_stb;
  logic [7:0] m2s_data;
  logic s2m_stb;
  logic [7:0] s2m_data;
  modport device (input m2s_stb, input m2s_data,
                  output s2m_stb, output s2m_data);
  modport host (output m2s_stb, output m2s_data,
                input s2m_stb, input s2m_data);
endinterface : rtu_link_if

/* File: verilog/rtu_master_end.sv */
// Master end: builds echo and multi-word write requests, sends them
// and collects the reply.
// Assumes the user holds req_* stable while req_valid is high.
`include "rtu_link_cfg.svh"
module rtu_master_end #(
  parameter int unsigned char_cycles = `CFG_CHAR_CYCLES,
  parameter int unsigned gap_cycles = `CFG_GAP_CYCLES,
  parameter int unsigned rsp_timeout = `CFG_RSP_TIMEOUT_CYCLES
) (
  input wire logic clk,
  input wire logic rstn,
  rtu_link_if.host link,
  input wire logic req_valid,
  output logic req_ready,
  output logic req_reject,
  input wire logic req_write,
  input wire rtu_link_pkg::byte_t req_slave,
  input wire rtu_link_pkg::word_t req_field,
  input wire rtu_link_pkg::word_t req_count,
  input wire logic [1:0] req_decimals,
  input wire rtu_link_pkg::word_t req_whole [`CFG_MAX_WORDS],
  input wire rtu_link_pkg::word_t req_frac [`CFG_MAX_WORDS],
  output logic rsp_valid,
  output logic rsp_timeout_flag,
  output logic rsp_crc_ok,
  output rtu_link_pkg::byte_t rsp_exc,
  output logic [5:0] rsp_len,
  output rtu_link_pkg::word_t rsp_field_a,
  output rtu_link_pkg::word_t rsp_field_b
);
  import rtu_link_pkg::*;

  // ==========================================================
  // State
  host_state_t st_r;
  byte_t tb_r [`CFG_BUF_BYTES];
  byte_t rb_r [8];
  logic [5:0] n_r, i_r;
  word_t crc_r;
  logic [31:0] idle_r, cnt_r;
  logic bad_cnt, tick, accept;

  assign bad_cnt = req_write &&
                   (req_count == 16'h0000 || req_count > `CFG_MAX_WORDS);
  // wait a full gap before sending
  assign req_ready = (st_r == HS_IDLE) && (idle_r == gap_cycles - 1);
  assign accept = req_valid && req_ready && !bad_cnt;
  assign tick = (st_r == HS_TX) && (cnt_r == 0);

  // Idle time since any link byte in either direction.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      idle_r <= '0;
    end else if (link.s2m_stb || link.m2s_stb || st_r == HS_TX) begin
      idle_r <= '0;
    end else if (idle_r != gap_cycles - 1) begin
      idle_r <= idle_r + 32'd1;
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= '0;
    end else if (st_r == HS_RSP || link.s2m_stb) begin
      cnt_r <= (st_r == HS_RSP && !link.s2m_stb) ? cnt_r + 32'd1 : '0;
    end else if (st_r != HS_TX || cnt_r == char_cycles - 1) begin
      cnt_r <= '0;
    end else begin
      cnt_r <= cnt_r + 32'd1;
    end
  end

  // ==========================================================
  // Request build, send and reply collection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st_r <= HS_IDLE;
      n_r <= '0;
      i_r <= '0;
      crc_r <= `CFG_CRC_INIT;
      req_reject <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_timeout_flag <= 1'b0;
      link.m2s_stb <= 1'b0;
      link.m2s_data <= 8'h00;
    end else begin
      req_reject <= req_valid && req_ready && bad_cnt;
      rsp_valid <= 1'b0;
      link.m2s_stb <= tick;
      unique case (st_r)
        HS_IDLE: begin
          if (accept) begin
            // address, command, start, count, bytes, data
            tb_r[0] <= req_slave;
            tb_r[1] <= req_write ? `CFG_CMD_WRITE : `CFG_CMD_DIAG;
            tb_r[2] <= req_field[15:8];
            tb_r[3] <= req_field[7:0];
            tb_r[4] <= req_count[15:8];
            tb_r[5] <= req_count[7:0];
            tb_r[6] <= {req_count[6:0], 1'b0};
            for (int w = 0; w < `CFG_MAX_WORDS; w++) begin
              tb_r[7 + 2 * w] <= 8'((req_whole[w] * pow10(req_decimals)
                                 + req_frac[w]) >> 8);
              tb_r[8 + 2 * w] <= 8'(req_whole[w] * pow10(req_decimals)
                                 + req_frac[w]);
            end
            n_r <= req_write ? 6'(req_count * 2 + 16'd7) : 6'd6;
            i_r <= '0;
            crc_r <= `CFG_CRC_INIT;
            st_r <= HS_TX;
          end
        end
        HS_TX: begin
          if (tick) begin
            i_r <= i_r + 6'd1;
            if (i_r < n_r) begin
              link.m2s_data <= tb_r[i_r];
              crc_r <= crc_step(crc_r, tb_r[i_r]);
            end else if (i_r == n_r) begin
              link.m2s_data <= crc_r[7:0];
            end else begin
              link.m2s_data <= crc_r[15:8];
              st_r <= HS_RSP;
              i_r <= '0;
              crc_r <= `CFG_CRC_INIT;
            end
          end
        end
        HS_RSP: begin
          if (link.s2m_stb) begin
            if (i_r < 6'd8) rb_r[i_r[2:0]] <= link.s2m_data;
            i_r <= i_r + 6'd1;
            crc_r <= crc_step(crc_r, link.s2m_data);
          end else if ((i_r != 6'd0 && cnt_r == gap_cycles - 1) ||
                       cnt_r == rsp_timeout - 1) begin
            rsp_valid <= 1'b1;
            rsp_timeout_flag <= (i_r == 6'd0);
            st_r <= HS_IDLE;
          end
        end
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  // Reply fields, valid while rsp_valid pulses and held after.
  assign rsp_len = i_r;
  assign rsp_crc_ok = (crc_r == 16'h0000) && (i_r > 6'd3);
  assign rsp_exc = rb_r[1][7] ? rb_r[2] : 8'h00;
  assign rsp_field_a = {rb_r[2], rb_r[3]};
  assign rsp_field_b = {rb_r[4], rb_r[5]};
endmodule : rtu_master_end

/* File: testbench/rtu_link_asserts.sv */
// Watches the byte link between the master end and the slave end.
// Assumes one clock, the link signals as plain inputs, slow pacing.
module rtu_link_asserts #(
  parameter int char_cyc = 8,
  parameter int gap_cyc = 28,
  parameter logic [7:0] own_addr = 8'h01
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic m2s_stb,
  input wire logic [7:0] m2s_data,
  input wire logic s2m_stb,
  input wire logic [7:0] s2m_data
);
  // ==========================================================
  // Frame tracking
  logic [15:0] m_cnt_r, s_cnt_r, s_crc_r;
  logic [3:0] m_pos, s_pos, m_idx_r, s_idx_r;
  logic [7:0] req_r [8];
  logic [7:0] cmd_r;
  logic m_start, s_start;

  // A strobe after a full idle gap opens a new frame.
  assign m_start = m_cnt_r == 16'(gap_cyc);
  assign s_start = s_cnt_r == 16'(gap_cyc);
  assign m_pos = m_start ? 4'h0 : m_idx_r;
  assign s_pos = s_start ? 4'h0 : s_idx_r;

  function automatic logic [15:0] crc_upd(logic [15:0] c, logic [7:0] b);
    logic [15:0] x = c ^ {8'h00, b};
    for (int i = 0; i < 8; i++) begin
      x = x[0] ? ((x >> 1) ^ 16'hA001) : (x >> 1);
    end
    return x;
  endfunction : crc_upd

  // Cycles since the last strobe; saturating keeps the counter small.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_cnt_r <= 16'(gap_cyc);
      s_cnt_r <= 16'(gap_cyc);
    end else begin
      m_cnt_r <= m2s_stb ? 16'h0001 : m_cnt_r + 16'(!m_start);
      s_cnt_r <= s2m_stb ? 16'h0001 : s_cnt_r + 16'(!s_start);
    end
  end

  // Request bytes are kept to hold the reply against.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      m_idx_r <= 4'h0;
      s_idx_r <= 4'h0;
      s_crc_r <= 16'hFFFF;
      cmd_r <= 8'h00;
    end else begin
      if (m2s_stb) begin
        m_idx_r <= m_pos + 4'(m_pos != 4'hF);
        if (m_pos < 4'h8) req_r[m_pos[2:0]] <= m2s_data;
      end
      if (s2m_stb) begin
        s_idx_r <= s_pos + 4'(s_pos != 4'hF);
        s_crc_r <= crc_upd(s_start ? 16'hFFFF : s_crc_r, s2m_data);
        if (s_pos == 4'h1) cmd_r <= s2m_data;
      end
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // An exception reply ends two bytes after its code, then goes quiet.
  sequence exc_tail;
    ##char_cyc s2m_stb ##char_cyc s2m_stb ##1 (!s2m_stb) [*8];
  endsequence

  a_s2m_pulse: assert property (s2m_stb |=> !s2m_stb)
    else $error("slave strobe too long");
  a_m2s_pacing: assert property (
    m2s_stb |-> m_start || m_cnt_r == 16'(char_cyc))
    else $error("master pace wrong");
  a_s2m_pacing: assert property (
    s2m_stb |-> s_start || s_cnt_r == 16'(char_cyc))
    else $error("slave pace wrong");
  a_reply_gap: assert property (s2m_stb && s_start |-> m_start)
    else $error("reply too early");
  a_request_gap: assert property (m2s_stb && m_start |-> s_start)
    else $error("request too early");
  a_reply_addr: assert property (
    s2m_stb && s_pos == 4'h0 |-> s2m_data == own_addr && req_r[0] == own_addr)
    else $error("foreign reply address");
  a_cmd_back: assert property (
    s2m_stb && s_pos == 4'h1 |-> s2m_data == req_r[1]
      || s2m_data == (req_r[1] | 8'h80))
    else $error("reply command wrong");
  a_echo_same: assert property (
    s2m_stb && s_pos inside {[4'h2:4'h7]} && cmd_r == 8'h08
      |-> s2m_data == req_r[s_pos[2:0]])
    else $error("echo differs");
  a_write_reply: assert property (
    s2m_stb && s_pos inside {[4'h2:4'h5]} && cmd_r == 8'h10
      |-> s2m_data == req_r[s_pos[2:0]])
    else $error("write reply differs");
  a_exc_frame: assert property (
    s2m_stb && s_pos == 4'h2 && cmd_r[7]
      |-> s2m_data inside {[8'h01:8'h09]} ##0 exc_tail)
    else $error("bad exception reply");
  a_reply_crc: assert property (
    !s2m_stb && s_cnt_r == 16'(gap_cyc - 1) |-> s_crc_r == 16'h0000)
    else $error("reply check wrong");
endmodule : rtu_link_asserts

/* File: testbench/modbus_rtu_slave_cmd_handler_bench.sv */
// Bench: master end and slave end face each other on one link; the
// bench plays the master's user and the slave's parameter store.
module modbus_rtu_slave_cmd_handler_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import rtu_link_pkg::*;
  localparam int char_cyc = 8, gap_cyc = 28;
  localparam byte_t exc_tbl [6] = '{8'h00, 8'h07, 8'h08, 8'h04, 8'h01, 8'h09};
  logic clk, rstn, req_valid, req_ready, req_reject, req_write, rsp_valid;
  logic rsp_timeout_flag, rsp_crc_ok, wr_stb, unlock_stb, drive_fault;
  logic chk_read_only, chk_run_locked, chk_conflict, drive_running, sys_locked;
  byte_t req_slave, rsp_exc;
  word_t req_field, req_count, rsp_field_a, rsp_field_b, chk_addr, pwd;
  word_t wr_addr, wr_raw, wr_whole, wr_frac, trip_addr;
  word_t req_whole [16], req_frac [16];
  logic [5:0] rsp_len;
  logic [1:0] dec;
  logic [2:0] trip;
  int fails = 0, n_tests = 0, n_wr = 0, n_unlock = 0;

  // ==========================================================
  // Store model: trip picks which refusal the store raises.
  assign chk_read_only = trip == 3'h1 && chk_addr == trip_addr;
  assign chk_run_locked = (trip inside {3'h2, 3'h6}) && chk_addr == trip_addr;
  assign drive_running = trip == 3'h2;
  assign chk_conflict = trip == 3'h3 && chk_addr == trip_addr;
  assign drive_fault = trip == 3'h4;
  assign sys_locked = trip == 3'h5;

  rtu_link_if rtu_link_if_inst (.clk(clk), .rstn(rstn));
  rtu_master_end #(.char_cycles(char_cyc), .gap_cycles(gap_cyc),
    .rsp_timeout(200)) rtu_master_end_inst (.clk(clk), .rstn(rstn),
    .link(rtu_link_if_inst.host), .req_valid(req_valid),
    .req_ready(req_ready), .req_reject(req_reject), .req_write(req_write),
    .req_slave(req_slave), .req_field(req_field), .req_count(req_count),
    .req_decimals(dec), .req_whole(req_whole), .req_frac(req_frac),
    .rsp_valid(rsp_valid), .rsp_timeout_flag(rsp_timeout_flag),
    .rsp_crc_ok(rsp_crc_ok), .rsp_exc(rsp_exc), .rsp_len(rsp_len),
    .rsp_field_a(rsp_field_a), .rsp_field_b(rsp_field_b));
  rtu_slave_end #(.char_cycles(char_cyc),
    .gap_cycles(gap_cyc)) rtu_slave_end_inst (.clk(clk), .rstn(rstn),
    .link(rtu_link_if_inst.device), .chk_addr(chk_addr),
    .chk_read_only(chk_read_only), .chk_run_locked(chk_run_locked),
    .chk_conflict(chk_conflict), .chk_decimals(dec),
    .drive_fault(drive_fault), .drive_running(drive_running),
    .sys_locked(sys_locked), .user_password_setting(pwd), .wr_stb(wr_stb),
    .wr_addr(wr_addr), .wr_raw(wr_raw), .wr_whole(wr_whole),
    .wr_frac(wr_frac), .unlock_stb(unlock_stb));
  rtu_link_asserts #(.char_cyc(char_cyc), .gap_cyc(gap_cyc))
    rtu_link_asserts_inst (.clk(clk), .rstn(rstn),
    .m2s_stb(rtu_link_if_inst.m2s_stb), .m2s_data(rtu_link_if_inst.m2s_data),
    .s2m_stb(rtu_link_if_inst.s2m_stb), .s2m_data(rtu_link_if_inst.s2m_data));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", what, exp, seen);
      fails++;
    end
  endtask : check

  task automatic test_done();
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : test_done

  // Words land one per cycle; scale one decimal place, so raw = w*10+f.
  always @(negedge clk) begin
    if (wr_stb === 1'b1 && n_wr < 16) begin
      check("wr_addr", wr_addr, req_field + 16'(n_wr));
      check("wr_raw", wr_raw,
            req_whole[n_wr] * 16'h000A + req_frac[n_wr]);
      check("wr_whole", wr_whole, req_whole[n_wr]);
      check("wr_frac", wr_frac, req_frac[n_wr]);
      n_wr++;
    end
    if (unlock_stb === 1'b1) n_unlock++;
  end

  // One request; len 0 means refused by the master, 3F means no reply.
  task automatic run(input logic wr, input byte_t sl, input word_t f,
                     input word_t c, input logic [5:0] len,
                     input byte_t exc, input int nw);
    int i, t;
    @(negedge clk);
    n_wr = 0;
    req_write = wr;
    req_slave = sl;
    req_field = f;
    req_count = c;
    req_valid = 1'b1;
    for (t = 0; t < 300 && req_ready !== 1'b1; t++) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    for (i = 0; i < 3000 && rsp_valid !== 1'b1 && req_reject !== 1'b1;
         i++) @(negedge clk);
    if (t == 300 || i == 3000) begin
      fails++;
      test_done();
    end
    if (len == 6'h00) begin
      check("req_reject", 16'(req_reject), 16'h0001);
    end else if (len == 6'h3F) begin
      check("rsp_timeout_flag", 16'(rsp_timeout_flag), 16'h0001);
    end else begin
      check("rsp_len", 16'(rsp_len), 16'(len));
      check("rsp_exc", 16'(rsp_exc), 16'(exc));
      check("rsp_crc_ok", 16'(rsp_crc_ok), 16'h0001);
      if (exc == 8'h00) begin
        check("rsp_field_a", rsp_field_a, f);
        check("rsp_field_b", rsp_field_b, c);
      end
    end
    check("stored words", 16'(n_wr), 16'(nw));
  endtask : run

  initial begin
    rstn = 1'b0;
    req_valid = 1'b0;
    trip = 3'h0;
    trip_addr = 16'h0011;
    dec = 2'h1;
    pwd = 16'h1388;
    for (int k = 0; k < 16; k++) begin
      req_whole[k] = 16'h0010 + 16'(k);
      req_frac[k] = 16'(k % 10);
    end
    repeat (10) @(negedge clk);
    rstn = 1'b1;
    run(1'b0, 8'h01, 16'h0000, 16'h12AB, 6'h08, 8'h00, 0);
    run(1'b0, 8'h01, 16'h0001, 16'h12AB, 6'h05, 8'h03, 0);
    $display("test echo done");
    // Raw words 4999 and 50, then both sides of the top of the address space.
    req_whole[0] = 16'h01F3;
    req_frac[0] = 16'h0009;
    req_whole[1] = 16'h0005;
    req_frac[1] = 16'h0000;
    run(1'b1, 8'h01, 16'h0004, 16'h0002, 6'h08, 8'h00, 2);
    run(1'b1, 8'h01, 16'hFFF0, 16'h0010, 6'h08, 8'h00, 16);
    run(1'b1, 8'h01, 16'hFFF1, 16'h0010, 6'h05, 8'h02, 0);
    $display("test write done");
    // A refusal must leave both words unstored; read-only, run and conflict trip on the second word.
    for (int k = 1; k < 6; k++) begin
      trip = 3'(k);
      run(1'b1, 8'h01, 16'h0010, 16'h0002, 6'h05, exc_tbl[k], 0);
    end
    trip = 3'h6;
    run(1'b1, 8'h01, 16'h0010, 16'h0002, 6'h08, 8'h00, 2);
    $display("test refusals done");
    // Locked store: only the password address may be written.
    trip = 3'h5;
    req_whole[0] = 16'h01F4;
    req_frac[0] = 16'h0000;
    run(1'b1, 8'h01, 16'h0F00, 16'h0001, 6'h08, 8'h00, 1);
    check("unlock count", 16'(n_unlock), 16'h0001);
    req_whole[0] = 16'h01F3;
    run(1'b1, 8'h01, 16'h0F00, 16'h0001, 6'h05, 8'h05, 0);
    check("unlock count", 16'(n_unlock), 16'h0001);
    trip = 3'h0;
    $display("test password done");
    run(1'b0, 8'h05, 16'h0000, 16'h12AB, 6'h3F, 8'h00, 0);
    run(1'b1, 8'h01, 16'h0010, 16'h0011, 6'h00, 8'h00, 0);
    run(1'b1, 8'h01, 16'h0010, 16'h0000, 6'h00, 8'h00, 0);
    $display("test limits done");
    test_done();
  end
endmodule : modbus_rtu_slave_cmd_handler_bench
